// >>> subsample_conv_ctrl_regs.sv
// Register bank, reset control and stream gating of the sub-sampling converter
//
// How it works
// - Soft reset restores registers, flushes FIFO, gates stream
// - Control bit 30 resets at once
// - Reset holds until software clears bit 30
// - After release, resync on next start of frame
// - Frame-aligned reset: wait frame end, 32 cycles
// - Stalled mid-frame, frame reset keeps waiting
// - Writes update processor-side copies immediately
// - Active set loads only at start of frame
// - Load only when commit flag is one
// - Enable bit starts and stops processing
// - Every access is a full 32-bit word
// - Fixed offsets 0x0000 to 0x0020, 0x0028 and 0x0100 decoded
// - Frame, line, pixel counters at 0x14-0x1C
`timescale 1ns/1ps

module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != (AW+1)'(DEPTH));
	assign out_valid = (count_q != '0);
	assign out_data = mem[rd_ptr_q];
	assign level = count_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (clk_en && push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!resetn || (clk_en && flush)) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (clk_en) begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + AW'(1);
			end
			if (push && !pop) begin
				count_q <= count_q + (AW+1)'(1);
			end else if (pop && !push) begin
				count_q <= count_q - (AW+1)'(1);
			end
		end
	end
endmodule : stream_fifo

module subsample_conv_ctrl_regs
	import subsample_conv_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// AXI4-Lite register port
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// AXI4-Stream video input
	input wire logic [DATA_W-1:0] s_axis_video_tdata,
	input wire logic s_axis_video_tvalid,
	output logic s_axis_video_tready,
	input wire logic s_axis_video_tuser,
	input wire logic s_axis_video_tlast,
	// AXI4-Stream video output
	output logic [DATA_W-1:0] m_axis_video_tdata,
	output logic m_axis_video_tvalid,
	input wire logic m_axis_video_tready,
	output logic m_axis_video_tuser,
	output logic m_axis_video_tlast,
	// Active parameter set used by the filter datapath
	output param_set_t active_params
);
	logic [31:0] control_word_q;
	logic [31:0] interrupt_mask_q;
	param_set_t shadow_q;
	logic [31:0] frame_cnt_q;
	logic [31:0] line_cnt_q;
	logic [31:0] pixel_cnt_q;
	logic [15:0] frame_line_q;
	logic [5:0] frame_rst_cnt_q;
	logic frame_rst_pend_q;
	frame_state_t state_q;
	logic int_rst;
	logic enabled;
	logic in_beat;
	logic keep_beat;
	logic frame_done;
	logic wr_fire;
	logic rd_fire;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic fifo_in_ready;
	video_beat_t fifo_in;
	video_beat_t fifo_out;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;

	function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] addr);
		logic [31:0] v;
		v = 32'h0000_0000;
		unique case (addr)
			OFF_CONTROL: v = control_word_q;
			OFF_STATUS: begin
				v[STAT_IN_FRAME_BIT] = (state_q == ST_IN_FRAME);
				v[STAT_RESET_BIT] = int_rst;
				v[STAT_SYNC_WAIT_BIT] = (state_q == ST_SYNC_WAIT);
			end
			OFF_ERROR: v = 32'h0000_0000;
			OFF_IRQ_MASK: v = interrupt_mask_q;
			OFF_REVISION: v = REVISION_VALUE;
			OFF_FRAME_CNT: v = frame_cnt_q;
			OFF_LINE_CNT: v = line_cnt_q;
			OFF_PIXEL_CNT: v = pixel_cnt_q;
			OFF_DIMENSIONS: v = shadow_q.dimensions;
			OFF_FORMAT: v = shadow_q.format;
			OFF_COEF: v = shadow_q.coef;
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_mux

	// Internal reset: held soft reset or the timed frame reset
	assign int_rst = control_word_q[CTRL_SOFT_RESET_BIT] || (frame_rst_cnt_q != 6'h00);
	assign enabled = control_word_q[CTRL_ENABLE_BIT];
	assign in_beat = s_axis_video_tvalid && s_axis_video_tready;
	// Beats before the first start of frame after a reset are dropped
	assign keep_beat = in_beat && (state_q != ST_SYNC_WAIT || s_axis_video_tuser);
	assign frame_done = keep_beat && s_axis_video_tlast && (frame_line_q + 16'h0001 >= active_params.dimensions[31:16]);
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	assign rd_fire = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	assign fifo_in = '{data: s_axis_video_tdata, sof: s_axis_video_tuser, eol: s_axis_video_tlast};
	assign fifo_out_ready = enabled && !int_rst && (!m_axis_video_tvalid || m_axis_video_tready);

	stream_fifo #(
		.WIDTH($bits(video_beat_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.clk_en(clk_en),
		.flush(int_rst),
		.in_valid(keep_beat),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out),
		.level(fifo_level)
	);

	// AXI4-Lite write channel; whole words only, strobes are not used
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= wr_fire;
			s_axi_wready <= wr_fire;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// AXI4-Lite read channel
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_arready <= rd_fire;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= read_mux(s_axi_araddr);
				s_axi_rresp <= RESP_OKAY;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Control word; soft reset bit survives its own reset so software must clear it
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			control_word_q <= CONTROL_RESET;
		end else if (clk_en) begin
			if (wr_fire && s_axi_awaddr == OFF_CONTROL) begin
				control_word_q <= s_axi_wdata;
			end else if (int_rst) begin
				control_word_q <= CONTROL_RESET;
				control_word_q[CTRL_SOFT_RESET_BIT] <= control_word_q[CTRL_SOFT_RESET_BIT];
			end else if (frame_rst_pend_q && !control_word_q[CTRL_FRAME_RESET_BIT]) begin
				control_word_q[CTRL_FRAME_RESET_BIT] <= 1'b0;
			end else if (control_word_q[CTRL_FRAME_RESET_BIT]) begin
				control_word_q[CTRL_FRAME_RESET_BIT] <= 1'b0;
			end
		end
	end

	// Processor-side copies, written at once
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			interrupt_mask_q <= IRQ_MASK_RESET;
			shadow_q <= '{dimensions: DIMENSIONS_RESET, format: FORMAT_RESET, coef: COEF_RESET};
		end else if (clk_en) begin
			if (int_rst) begin
				interrupt_mask_q <= IRQ_MASK_RESET;
				shadow_q <= '{dimensions: DIMENSIONS_RESET, format: FORMAT_RESET, coef: COEF_RESET};
			end else if (wr_fire) begin
				unique case (s_axi_awaddr)
					OFF_IRQ_MASK: interrupt_mask_q <= s_axi_wdata;
					OFF_DIMENSIONS: shadow_q.dimensions <= s_axi_wdata;
					OFF_FORMAT: shadow_q.format <= s_axi_wdata;
					OFF_COEF: shadow_q.coef <= s_axi_wdata;
					default: ;
				endcase
			end
		end
	end

	// Active set loads at a kept start-of-frame beat, only while commit is on
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			active_params <= '{dimensions: DIMENSIONS_RESET, format: FORMAT_RESET, coef: COEF_RESET};
		end else if (clk_en) begin
			if (int_rst) begin
				active_params <= '{dimensions: DIMENSIONS_RESET, format: FORMAT_RESET, coef: COEF_RESET};
			end else if (keep_beat && s_axis_video_tuser && control_word_q[CTRL_COMMIT_BIT]) begin
				active_params <= shadow_q;
			end
		end
	end

	// Frame tracking
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state_q <= ST_SYNC_WAIT;
			frame_line_q <= 16'h0000;
		end else if (clk_en) begin
			if (int_rst) begin
				state_q <= ST_SYNC_WAIT;
				frame_line_q <= 16'h0000;
			end else if (keep_beat) begin
				if (s_axis_video_tuser) begin
					frame_line_q <= 16'h0000;
				end
				if (frame_done) begin
					state_q <= ST_IDLE;
					frame_line_q <= 16'h0000;
				end else begin
					state_q <= ST_IN_FRAME;
					if (s_axis_video_tlast) begin
						frame_line_q <= frame_line_q + 16'h0001;
					end
				end
			end
		end
	end

	// Frame-aligned reset: park the request until no frame is in flight
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			frame_rst_pend_q <= 1'b0;
			frame_rst_cnt_q <= 6'h00;
		end else if (clk_en) begin
			if (frame_rst_cnt_q != 6'h00) begin
				frame_rst_cnt_q <= frame_rst_cnt_q - 6'h01;
			end else if (frame_rst_pend_q || control_word_q[CTRL_FRAME_RESET_BIT]) begin
				// A stalled frame keeps the request parked; a new start of frame also ends it
				if (state_q != ST_IN_FRAME || frame_done || (keep_beat && s_axis_video_tuser)) begin
					frame_rst_pend_q <= 1'b0;
					frame_rst_cnt_q <= FRAME_RESET_CYCLES;
				end else begin
					frame_rst_pend_q <= 1'b1;
				end
			end
		end
	end

	// Throughput counters
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			frame_cnt_q <= 32'h0000_0000;
			line_cnt_q <= 32'h0000_0000;
			pixel_cnt_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (int_rst) begin
				frame_cnt_q <= 32'h0000_0000;
				line_cnt_q <= 32'h0000_0000;
				pixel_cnt_q <= 32'h0000_0000;
			end else if (keep_beat) begin
				pixel_cnt_q <= pixel_cnt_q + 32'h0000_0001;
				if (s_axis_video_tlast) begin
					line_cnt_q <= line_cnt_q + 32'h0000_0001;
				end
				if (frame_done) begin
					frame_cnt_q <= frame_cnt_q + 32'h0000_0001;
				end
			end
		end
	end

	// Input ready is registered, so it is dropped one entry early to cover the beat in flight
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			s_axis_video_tready <= 1'b0;
		end else if (clk_en) begin
			s_axis_video_tready <= enabled && !int_rst && fifo_in_ready
				&& (fifo_level < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - 1));
		end
	end

	// Output register stage
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			m_axis_video_tvalid <= 1'b0;
			m_axis_video_tdata <= '0;
			m_axis_video_tuser <= 1'b0;
			m_axis_video_tlast <= 1'b0;
		end else if (clk_en) begin
			if (int_rst || !enabled) begin
				m_axis_video_tvalid <= 1'b0;
			end else if (fifo_out_ready) begin
				m_axis_video_tvalid <= fifo_out_valid;
				if (fifo_out_valid) begin
					m_axis_video_tdata <= fifo_out.data;
					m_axis_video_tuser <= fifo_out.sof;
					m_axis_video_tlast <= fifo_out.eol;
				end
			end
		end
	end
endmodule : subsample_conv_ctrl_regs

// >>> subsample_conv_pkg.sv
// Shared constants and types for the sub-sampling converter control block
package subsample_conv_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 24;
	localparam int FIFO_DEPTH = 16;
	// Register byte offsets
	localparam logic [11:0] OFF_CONTROL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_ERROR = 12'h008;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
	localparam logic [11:0] OFF_REVISION = 12'h010;
	localparam logic [11:0] OFF_FRAME_CNT = 12'h014;
	localparam logic [11:0] OFF_LINE_CNT = 12'h018;
	localparam logic [11:0] OFF_PIXEL_CNT = 12'h01C;
	localparam logic [11:0] OFF_DIMENSIONS = 12'h020;
	localparam logic [11:0] OFF_FORMAT = 12'h028;
	localparam logic [11:0] OFF_COEF = 12'h100;
	// Control word fields
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_COMMIT_BIT = 1;
	localparam int CTRL_SOFT_RESET_BIT = 30;
	localparam int CTRL_FRAME_RESET_BIT = 31;
	// Status word fields
	localparam int STAT_IN_FRAME_BIT = 0;
	localparam int STAT_RESET_BIT = 1;
	localparam int STAT_SYNC_WAIT_BIT = 2;
	// Reset values
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
	localparam logic [31:0] IRQ_MASK_RESET = 32'h0000_0000;
	localparam logic [31:0] DIMENSIONS_RESET = 32'h0438_0780;
	localparam logic [31:0] FORMAT_RESET = 32'h0000_0000;
	localparam logic [31:0] COEF_RESET = 32'h0000_0000;
	// Arbitrary revision value, names no real part
	localparam logic [31:0] REVISION_VALUE = 32'h0001_0000;
	// Frame-aligned internal reset length
	localparam logic [5:0] FRAME_RESET_CYCLES = 6'h20;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic sof;
		logic eol;
	} video_beat_t;

	typedef struct packed {
		logic [31:0] dimensions;
		logic [31:0] format;
		logic [31:0] coef;
	} param_set_t;

	typedef enum logic [1:0] {
		ST_SYNC_WAIT,
		ST_IDLE,
		ST_IN_FRAME
	} frame_state_t;
endpackage : subsample_conv_pkg

// >>> subsample_conv_ctrl_regs_assertions.sv
// Port-level checker for the converter register block
`timescale 1ns/1ps
module subsample_conv_ctrl_regs_chk
	import subsample_conv_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic s_axis_video_tready,
	input wire logic m_axis_video_tvalid
);
	logic ctl_wr;
	logic rd_new;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	assign ctl_wr = s_axi_awready && s_axi_awvalid && s_axi_awaddr == OFF_CONTROL;
	assign rd_new = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready |=> s_axi_awready && s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (rd_new |=> s_axi_arready && s_axi_rvalid)
		else $error("read not answered");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than a cycle");
	a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY)
		else $error("write response not okay");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_hole_zero: assert property (rd_new && s_axi_araddr == 12'h024 |=> s_axi_rdata == 32'h0000_0000)
		else $error("unused offset not zero");
	a_revision_value: assert property (rd_new && s_axi_araddr == OFF_REVISION |=> s_axi_rdata == REVISION_VALUE)
		else $error("revision value wrong");
	a_soft_gate: assert property (ctl_wr && s_axi_wdata[CTRL_SOFT_RESET_BIT] |=> ##1 (!s_axis_video_tready && !m_axis_video_tvalid) [*4])
		else $error("stream not gated in soft reset");
	a_disable_gate: assert property (ctl_wr && !s_axi_wdata[CTRL_ENABLE_BIT] |=> ##1 !s_axis_video_tready && !m_axis_video_tvalid)
		else $error("stream not gated when disabled");
	a_wready_pair: assert property (s_axi_wready == s_axi_awready)
		else $error("wready not paired with awready");
	a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == RESP_OKAY)
		else $error("read response not okay");
endmodule : subsample_conv_ctrl_regs_chk
bind subsample_conv_ctrl_regs subsample_conv_ctrl_regs_chk chk_u (.*);

// >>> cpu_bus_model.sv
// Processor model issuing register accesses on the control port
`timescale 1ns/1ps
module cpu_bus_model
	import subsample_conv_pkg::*;
(
	input wire logic core_clk,
	output logic [ADDR_W-1:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [ADDR_W-1:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready,
	output logic hung
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
		s_axi_wstrb = 4'hF;
	end
	// Response is taken a cycle late on purpose, so the device must hold it
	task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		@(negedge core_clk);
		s_axi_awaddr = a;
		s_axi_araddr = a;
		s_axi_wdata = d;
		s_axi_awvalid = wr;
		s_axi_wvalid = wr;
		s_axi_arvalid = !wr;
		n = 0;
		do @(posedge core_clk); while (!(wr ? s_axi_awready : s_axi_arready) && ++n < 64);
		hung |= n >= 64;
		@(negedge core_clk);
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
		s_axi_awaddr = ~a;
		s_axi_araddr = ~a;
		s_axi_wdata = ~d;
		@(negedge core_clk);
		s_axi_bready = wr;
		s_axi_rready = !wr;
		n = 0;
		do @(posedge core_clk); while (!(wr ? s_axi_bvalid : s_axi_rvalid) && ++n < 64);
		hung |= n >= 64;
		@(negedge core_clk);
		s_axi_bready = 1'b0;
		s_axi_rready = 1'b0;
	endtask : access
endmodule : cpu_bus_model

// >>> subsample_conv_ctrl_regs_tb_top.sv
// Self-checking bench for the converter register block
`timescale 1ns/1ps
module subsample_conv_ctrl_regs_tb_top;
	import subsample_conv_pkg::*;
	logic core_clk = 0, resetn = 0, clk_en = 1, hung;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dims, seed = 32'h0001_52A0;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [DATA_W-1:0] s_axis_video_tdata = '0, m_axis_video_tdata;
	logic s_axis_video_tvalid = 0, s_axis_video_tready, s_axis_video_tuser = 0, s_axis_video_tlast = 0;
	logic m_axis_video_tvalid, m_axis_video_tready = 0, m_axis_video_tuser, m_axis_video_tlast;
	param_set_t active_params;
	int n_errors = 0, samples_checked = 0;
	logic [63:0] reads[$];
	logic [DATA_W+1:0] beats[$];
	logic [11:0] offs[10] = '{OFF_CONTROL, OFF_ERROR, OFF_IRQ_MASK, OFF_REVISION, OFF_FRAME_CNT,
		OFF_LINE_CNT, OFF_PIXEL_CNT, OFF_DIMENSIONS, OFF_FORMAT, 12'h024};
	logic [31:0] exps[10] = '{CONTROL_RESET, 32'h0, IRQ_MASK_RESET, REVISION_VALUE, 32'h0, 32'h0,
		32'h0, DIMENSIONS_RESET, FORMAT_RESET, 32'h0};
	subsample_conv_ctrl_regs dut_u (.*);
	cpu_bus_model cpu_u (.*);
	initial forever #5 core_clk = ~core_clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic check(input string what, input logic [95:0] exp, input logic [95:0] seen);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic check_read(input logic [31:0] exp, input logic [31:0] seen, input logic [1:0] resp);
		check("read data", 96'(exp), 96'(seen));
		check("read response", 96'(RESP_OKAY), 96'(resp));
	endtask : check_read
	task automatic check_beat(input logic [DATA_W+1:0] exp, input logic [DATA_W+1:0] seen);
		check("beat", 96'(exp), 96'(seen));
	endtask : check_beat
	task automatic check_params(input logic [95:0] exp);
		check("params", exp, active_params);
	endtask : check_params
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
		reads.push_back({m, exp & m});
		cpu_u.access(1'b0, a, 32'h0);
	endtask : rd
	// Released data is inverted so a late sample cannot match by luck
	task automatic beat(input logic [DATA_W-1:0] d, input logic sof, input logic eol, input logic keep);
		int n = 0;
		if (keep)
			beats.push_back({eol, sof, d});
		@(negedge core_clk);
		s_axis_video_tdata = d;
		s_axis_video_tuser = sof;
		s_axis_video_tlast = eol;
		s_axis_video_tvalid = 1'b1;
		do @(posedge core_clk); while (!s_axis_video_tready && ++n < 64);
		@(negedge core_clk);
		s_axis_video_tvalid = 1'b0;
		s_axis_video_tdata = ~d;
		if (n >= 64) begin
			n_errors++;
			complete_run();
		end
	endtask : beat
	task automatic drain();
		for (int i = 0; i < 300 && beats.size() > 0; i++)
			@(posedge core_clk);
		check("beats left", 32'h0, beats.size());
		if (beats.size() > 0)
			complete_run();
	endtask : drain
	always @(negedge core_clk)
		m_axis_video_tready <= rnd() % 4 != 0;
	always @(posedge core_clk) begin
		logic [63:0] r;
		if (hung) begin
			n_errors++;
			complete_run();
		end
		if (s_axi_rvalid && s_axi_rready) begin
			r = reads.size() > 0 ? reads.pop_front() : 'x;
			check_read(r[31:0], s_axi_rdata & r[63:32], s_axi_rresp);
		end
		if (m_axis_video_tvalid && m_axis_video_tready)
			check_beat(beats.size() > 0 ? beats.pop_front() : 'x,
				{m_axis_video_tlast, m_axis_video_tuser, m_axis_video_tdata});
	end
	initial begin
		dims = {16'(rnd() % 16'h1DE1 + 16'h20), 16'(rnd() % 16'h1DE1 + 16'h20)};
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		foreach (offs[i]) rd(offs[i], exps[i]);
		rd(OFF_STATUS, 32'h4);
		cpu_u.access(1'b1, 12'h024, rnd());
		rd(12'h024, 32'h0);
		cpu_u.access(1'b1, OFF_IRQ_MASK, dims);
		rd(OFF_IRQ_MASK, dims);
		cpu_u.access(1'b1, OFF_CONTROL, 32'h8000_0000);
		rd(OFF_STATUS, 32'h2, 32'h2);
		rd(OFF_CONTROL, 32'h0, 32'h8000_0000);
		// Reads land every 5 cycles: reset still on 30 cycles after the request, off after 35
		for (int i = 0; i < 5; i++)
			rd(OFF_STATUS, (i < 4) ? 32'h2 : 32'h0, 32'h2);
		cpu_u.access(1'b1, OFF_CONTROL, 32'h1);
		cpu_u.access(1'b1, OFF_DIMENSIONS, dims);
		cpu_u.access(1'b1, OFF_FORMAT, ~dims);
		cpu_u.access(1'b1, OFF_COEF, dims ^ 32'h0F0F_0F0F);
		rd(OFF_DIMENSIONS, dims);
		rd(OFF_FORMAT, ~dims);
		beat(24'h000111, 1'b1, 1'b0, 1'b1);
		for (int i = 0; i < 3; i++)
			beat(24'(rnd()), 1'b0, i == 2, 1'b1);
		repeat (3) @(negedge core_clk);
		check_params({DIMENSIONS_RESET, FORMAT_RESET, COEF_RESET});
		cpu_u.access(1'b1, OFF_CONTROL, 32'h3);
		check_params({DIMENSIONS_RESET, FORMAT_RESET, COEF_RESET});
		beat(24'h000222, 1'b1, 1'b0, 1'b1);
		repeat (3) @(negedge core_clk);
		check_params({dims, ~dims, dims ^ 32'h0F0F_0F0F});
		drain();
		rd(OFF_PIXEL_CNT, 32'h5);
		rd(OFF_LINE_CNT, 32'h1);
		rd(OFF_FRAME_CNT, 32'h0);
		cpu_u.access(1'b1, OFF_CONTROL, 32'h0);
		repeat (3) @(negedge core_clk);
		check("ready", 32'h0, s_axis_video_tready);
		rd(OFF_DIMENSIONS, dims);
		// Frame still open and the input idle, so the frame reset must stay parked
		cpu_u.access(1'b1, OFF_CONTROL, 32'h8000_0001);
		rd(OFF_STATUS, 32'h0, 32'h2);
		beat(24'h000444, 1'b1, 1'b0, 1'b0);
		rd(OFF_STATUS, 32'h2, 32'h2);
		repeat (40) @(posedge core_clk);
		cpu_u.access(1'b1, OFF_IRQ_MASK, dims);
		cpu_u.access(1'b1, OFF_DIMENSIONS, dims);
		cpu_u.access(1'b1, OFF_CONTROL, 32'h4000_0003);
		rd(OFF_IRQ_MASK, IRQ_MASK_RESET);
		rd(OFF_DIMENSIONS, DIMENSIONS_RESET);
		repeat (50) @(posedge core_clk);
		rd(OFF_STATUS, 32'h2, 32'h2);
		cpu_u.access(1'b1, OFF_CONTROL, 32'h1);
		rd(OFF_STATUS, 32'h4, 32'h6);
		beat(24'h0000AB, 1'b0, 1'b0, 1'b0);
		beat(24'h000333, 1'b1, 1'b1, 1'b1);
		drain();
		complete_run();
	end
endmodule : subsample_conv_ctrl_regs_tb_top
